// ### pkg/thermal_pkg.sv
package thermal_pkg;

  // register indices selected through the pointer
  localparam logic [7:0] REG_CAP = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_HIGH = 8'h02;
  localparam logic [7:0] REG_LOW = 8'h03;
  localparam logic [7:0] REG_CRIT = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h05;
  localparam logic [7:0] REG_MFR = 8'h06;
  localparam logic [7:0] REG_DEV = 8'h07;
  localparam logic [7:0] REG_RES = 8'h08;

  // reset values
  localparam logic [15:0] CAP_RESET = 16'h004f;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] RES_RESET = 16'h000f;
  localparam logic [10:0] LIMIT_RESET = 11'h000;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // capability bit positions
  localparam int CAP_ACTION_POS = 7;
  localparam int CAP_TIMEOUT_POS = 6;
  localparam int CAP_RANGE_POS = 2;
  localparam int CAP_ACC_POS = 1;
  localparam int CAP_ALERT_POS = 0;
  // resolution field sits in bits 4:3 of capability and resolution words
  localparam int RES_LSB = 3;
  // fixed low bits of the resolution word
  localparam logic [2:0] RES_FIXED = 3'h7;

  // hysteresis margins in quarter-degree steps: 0, 1.5, 3, 6 degrees
  localparam logic signed [11:0] MARGIN_0 = 12'sh000;
  localparam logic signed [11:0] MARGIN_1 = 12'sh006;
  localparam logic signed [11:0] MARGIN_2 = 12'sh00c;
  localparam logic signed [11:0] MARGIN_3 = 12'sh018;

  // configuration word, bit 15 down to bit 0
  typedef struct packed {
    logic [4:0] reserved_bits;
    logic [1:0] hyst_select;
    logic shutdown_request;
    logic critical_limit_lock;
    logic alarm_limit_lock;
    logic alert_clear;
    logic alert_status;
    logic alert_enable;
    logic critical_only_select;
    logic alert_polarity;
    logic alert_mode_int;
  } cfg_word_s;

  // register access request: pointer byte and/or data word
  typedef struct packed {
    logic ptr_we;
    logic [7:0] ptr;
    logic we;
    logic [15:0] wdata;
  } reg_req_s;

  // whole state of the block
  typedef struct packed {
    logic [7:0] ptr;
    cfg_word_s cfg;
    logic [10:0] high;
    logic [10:0] low;
    logic [10:0] crit;
    logic [1:0] temp_resolution_field;
    logic [12:0] temp;
    logic above_high;
    logic below_low;
    logic above_crit;
    logic alert_q;
    logic released;
    logic [15:0] rdata;
  } state_s;

endpackage : thermal_pkg

// ### design/thermal_capability_config_compare.sv
`timescale 1ns/1ps

// What this block does
// [R1] capability upper byte reads zero, ignores writes
// [R2] action 0: alert frozen through shutdown
// [R3] action 1: alert released through shutdown
// [R4] timeout capability bit reports 1 by default
// [R5] capability bit 5 reads 0; host accepts either
// [R6] resolution field encodes data LSB size
// [R7] range bit 1: negative readings keep sign
// [R8] accuracy bit reads 1 by default
// [R9] alert support bit reads 1 by default
// [R10] configuration word holds alert controls, resets zero
// [R11] configuration bits 15..11 read zero
// [R12] hysteresis margin applies to falling temperature
// [R13] either lock freezes the hysteresis field
// [R14] comparator alert pin deasserts only at or below high or critical limit minus margin
// [R15] below-window sets below low minus margin
// [R16] limits and data are two's complement
// [R17] finer resolution extends only the data word
// [R18] comparisons use bits 12 down to 2
// [R19] host writes limit bit 2 zero at 0.5C
// [R20] clear bit releases interrupt alert until retrigger
// [R21] critical alert cannot be cleared
// [R22] comparator mode ignores register accesses
// [R23] hysteresis decode 0, 1.5, 3, 6 degrees
// [R24] capability resolution mirrors resolution register
module thermal_capability_config_compare
  import thermal_pkg::*;
#(
  parameter logic shutdown_alert_action = CAP_RESET[CAP_ACTION_POS],
  parameter logic bus_timeout_range = CAP_RESET[CAP_TIMEOUT_POS],
  parameter logic temp_range_signed = CAP_RESET[CAP_RANGE_POS],
  parameter logic accuracy_grade = CAP_RESET[CAP_ACC_POS],
  parameter logic alert_supported = CAP_RESET[CAP_ALERT_POS],
  parameter logic [15:0] maker_code = 16'h1234, // arbitrary value
  parameter logic [15:0] part_code = 16'h5678 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access behind the pointer
  input wire reg_req_s req,
  output logic [15:0] rdata,
  // sampling engine
  input wire logic sample_valid,
  input wire logic [12:0] sample_temp,
  output logic shutdown_active,
  output logic [1:0] temp_resolution_field,
  // open-drain alert pin
  output logic alert_out,
  output logic alert_oe
);

  state_s s;
  state_s next_s;
  logic [15:0] cap_word;
  logic alert_active;
  logic [7:0] wptr;
  logic clear_req;
  logic signed [11:0] t_cmp;
  logic signed [11:0] margin;
  cfg_word_s wcfg;

  // hysteresis select to margin in quarter degrees
  function automatic logic signed [11:0] hyst_margin(input logic [1:0] sel);
    case (sel)
      2'h0: hyst_margin = MARGIN_0;
      2'h1: hyst_margin = MARGIN_1;
      2'h2: hyst_margin = MARGIN_2;
      default: hyst_margin = MARGIN_3;
    endcase
  endfunction : hyst_margin

  // sign-extend an 11-bit quarter-degree value
  function automatic logic signed [11:0] sx(input logic [10:0] v);
    sx = signed'({v[10], v});
  endfunction : sx

  // clear data bits finer than the programmed resolution
  function automatic logic [12:0] res_mask(input logic [12:0] v, input logic [1:0] r);
    case (r)
      2'h0: res_mask = {v[12:3], 3'h0};
      2'h1: res_mask = {v[12:2], 2'h0};
      2'h2: res_mask = {v[12:1], 1'h0};
      default: res_mask = v;
    endcase
  endfunction : res_mask

  // capability word assembled from straps and resolution
  always_comb begin
    cap_word = 16'h0000; // [R1] [R5]
    cap_word[CAP_ACTION_POS] = shutdown_alert_action;
    cap_word[CAP_TIMEOUT_POS] = bus_timeout_range; // [R4]
    cap_word[RES_LSB +: 2] = s.temp_resolution_field; // [R6] [R24]
    cap_word[CAP_RANGE_POS] = temp_range_signed; // [R7]
    cap_word[CAP_ACC_POS] = accuracy_grade; // [R8]
    cap_word[CAP_ALERT_POS] = alert_supported; // [R9]
  end

  // write decode helpers
  assign wptr = req.ptr_we ? req.ptr : s.ptr;
  assign wcfg = cfg_word_s'(req.wdata);
  assign clear_req = req.we && wptr == REG_CFG && wcfg.alert_clear;
  assign margin = hyst_margin(s.cfg.hyst_select); // [R23]
  assign alert_active = s.alert_q & ~s.released;

  // next-state logic: registers, comparators and alert
  always_comb begin
    logic [12:0] smp;
    logic win_now;
    logic win_chg;
    smp = sample_temp;
    win_now = 1'b0;
    win_chg = 1'b0;
    next_s = s;
    next_s.cfg.alert_clear = 1'b0;
    if (!temp_range_signed && sample_temp[12]) begin
      smp = 13'h0000; // [R7]
    end
    t_cmp = sx(smp[12:2]); // [R18]
    if (sample_valid && !s.cfg.shutdown_request) begin
      next_s.temp = res_mask(smp, s.temp_resolution_field); // [R17]
      next_s.released = 1'b0;
      if (t_cmp > sx(s.high)) begin
        next_s.above_high = 1'b1;
      end else if (t_cmp <= sx(s.high) - margin) begin
        next_s.above_high = 1'b0; // [R12]
      end
      if (t_cmp > sx(s.crit)) begin
        next_s.above_crit = 1'b1;
      end else if (t_cmp <= sx(s.crit) - margin) begin
        next_s.above_crit = 1'b0; // [R12]
      end
      if (t_cmp < sx(s.low) - margin) begin
        next_s.below_low = 1'b1; // [R15]
      end else if (t_cmp >= sx(s.low)) begin
        next_s.below_low = 1'b0; // [R15]
      end
    end
    if (req.ptr_we) begin
      next_s.ptr = req.ptr;
    end
    if (req.we) begin
      case (wptr)
        REG_CFG: begin
          next_s.cfg.alert_mode_int = wcfg.alert_mode_int; // [R10]
          next_s.cfg.alert_polarity = wcfg.alert_polarity;
          next_s.cfg.critical_only_select = wcfg.critical_only_select;
          next_s.cfg.alert_enable = wcfg.alert_enable;
          next_s.cfg.alert_clear = wcfg.alert_clear;
          next_s.cfg.alarm_limit_lock = s.cfg.alarm_limit_lock | wcfg.alarm_limit_lock;
          next_s.cfg.critical_limit_lock =
            s.cfg.critical_limit_lock | wcfg.critical_limit_lock;
          next_s.cfg.shutdown_request = wcfg.shutdown_request;
          if (!(s.cfg.alarm_limit_lock || s.cfg.critical_limit_lock)) begin
            next_s.cfg.hyst_select = wcfg.hyst_select; // [R13]
          end
          if (wcfg.shutdown_request && !s.cfg.shutdown_request && shutdown_alert_action) begin
            next_s.released = 1'b1; // [R3]
          end
        end
        REG_HIGH: begin
          if (!s.cfg.alarm_limit_lock) next_s.high = req.wdata[12:2]; // [R16]
        end
        REG_LOW: begin
          if (!s.cfg.alarm_limit_lock) next_s.low = req.wdata[12:2]; // [R16]
        end
        REG_CRIT: begin
          if (!s.cfg.critical_limit_lock) next_s.crit = req.wdata[12:2]; // [R16]
        end
        REG_RES: next_s.temp_resolution_field = req.wdata[RES_LSB +: 2]; // [R24]
        default: ;
      endcase
    end
    // alert follows the comparators only while active; frozen in shutdown
    if (!s.cfg.shutdown_request) begin // [R2]
      win_now = ~s.cfg.critical_only_select & (next_s.above_high | next_s.below_low);
      win_chg = ~s.cfg.critical_only_select &
        ((next_s.above_high ^ s.above_high) | (next_s.below_low ^ s.below_low));
      if (!s.cfg.alert_mode_int) begin
        next_s.alert_q = next_s.above_crit | win_now; // [R14] [R22]
      end else begin
        // a new trigger wins over a clear in the same cycle
        next_s.alert_q = (s.alert_q & ~clear_req) | win_chg | next_s.above_crit; // [R20] [R21]
      end
    end
    next_s.cfg.alert_status = 1'b0;
    next_s.cfg.reserved_bits = 5'h00;
    // read data follows the pointer one cycle later
    case (s.ptr)
      REG_CAP: next_s.rdata = cap_word;
      REG_CFG: begin
        next_s.rdata = {5'h00, s.cfg[10:0]}; // [R11]
        next_s.rdata[4] = alert_active;
        next_s.rdata[5] = 1'b0;
      end
      REG_HIGH: next_s.rdata = {3'h0, s.high, 2'h0};
      REG_LOW: next_s.rdata = {3'h0, s.low, 2'h0};
      REG_CRIT: next_s.rdata = {3'h0, s.crit, 2'h0};
      REG_TEMP: next_s.rdata = {s.above_crit, s.above_high, s.below_low, s.temp};
      REG_MFR: next_s.rdata = maker_code;
      REG_DEV: next_s.rdata = part_code;
      REG_RES: next_s.rdata = {11'h000, s.temp_resolution_field, RES_FIXED};
      default: next_s.rdata = 16'h0000;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.ptr <= PTR_RESET;
      s.cfg <= cfg_word_s'(CFG_RESET); // [R10]
      s.high <= LIMIT_RESET;
      s.low <= LIMIT_RESET;
      s.crit <= LIMIT_RESET;
      s.temp_resolution_field <= RES_RESET[RES_LSB +: 2];
    end else begin
      s <= next_s;
    end
  end

  // outputs; pin pulled low when asserted (active low) or idle (active high)
  assign rdata = s.rdata;
  assign shutdown_active = s.cfg.shutdown_request;
  assign temp_resolution_field = s.temp_resolution_field;
  assign alert_out = 1'b0;
  assign alert_oe = s.cfg.alert_enable & (alert_active ^ s.cfg.alert_polarity);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cap_upper_zero: assert property ((s.ptr == REG_CAP) |=> rdata[15:8] == 8'h00) // [R1]
    else $error("capability upper byte not zero");
  a_cfg_reserved_zero: assert property ((s.ptr == REG_CFG) |=> rdata[15:11] == 5'h00) // [R11]
    else $error("configuration reserved bits not zero");
  a_hyst_lock_hold: assert property ( // [R13]
    (s.cfg.alarm_limit_lock || s.cfg.critical_limit_lock) |=> $stable(s.cfg.hyst_select))
    else $error("hysteresis changed while locked");
  a_crit_no_clear: assert property ( // [R21]
    (s.above_crit && !s.cfg.shutdown_request && !sample_valid) |=> s.alert_q)
    else $error("critical alert released");
  a_shutdown_request_release: assert property ( // [R3]
    (shutdown_alert_action && $rose(s.cfg.shutdown_request)) |-> !alert_active)
    else $error("alert not released on shutdown");
  a_shutdown_request_freeze: assert property ( // [R2]
    (s.cfg.shutdown_request && $past(s.cfg.shutdown_request)) |-> $stable(s.alert_q))
    else $error("alert changed during shutdown");
  a_high_hyst: assert property ( // [R12]
    (sample_valid && !s.cfg.shutdown_request && s.above_high && t_cmp > sx(s.high) - margin)
    |=> s.above_high)
    else $error("high flag cleared inside hysteresis");
  a_low_set: assert property ( // [R15]
    (sample_valid && !s.cfg.shutdown_request && t_cmp < sx(s.low) - margin) |=> s.below_low)
    else $error("below window flag not set");
  a_int_clear: assert property ( // [R20]
    (clear_req && s.cfg.alert_mode_int && !s.above_crit && !sample_valid
      && !s.cfg.shutdown_request) |=> !s.alert_q)
    else $error("interrupt alert not cleared");
  a_cmp_access: assert property ( // [R22]
    (!s.cfg.alert_mode_int && !s.cfg.shutdown_request && !sample_valid && !clear_req)
    ##1 (!sample_valid) |-> $stable(s.alert_q))
    else $error("comparator alert moved without sample");
  a_res_mirror: assert property ( // [R24]
    (req.we && wptr == REG_RES) |=> cap_word[4:3] == $past(req.wdata[4:3]))
    else $error("capability resolution not mirrored");
  // capability bit 5 is left at zero
  a_cap_bit5_zero: assert property ((s.ptr == REG_CAP) |=> !rdata[5]) // [R5]
    else $error("capability bit 5 not zero");
  // capability low bits follow their straps
  a_cap_straps: assert property ( // [R4] [R7] [R8] [R9]
    (s.ptr == REG_CAP) |=> rdata[6] == bus_timeout_range && rdata[2:0] ==
      {temp_range_signed, accuracy_grade, alert_supported})
    else $error("capability strap bits wrong");
  // a disabled pin is never pulled
  a_alert_disabled: assert property (!s.cfg.alert_enable |-> !alert_oe) // [R10]
    else $error("alert pin driven while disabled");
  // comparator pin holds until the high flag clears at or below limit minus margin
  a_pin_hyst: assert property ( // [R14]
    (!s.cfg.alert_mode_int && !s.cfg.shutdown_request && !s.cfg.critical_only_select
      && s.above_high && (!sample_valid || t_cmp > sx(s.high) - margin)) |=> s.alert_q)
    else $error("alert pin dropped inside hysteresis");
  // coarse resolution stores no bits below its step
  a_res_coarse: assert property ( // [R17]
    (sample_valid && !s.cfg.shutdown_request && s.temp_resolution_field == 2'h0)
    |=> s.temp[2:0] == 3'h0)
    else $error("temperature keeps bits below resolution");
  // limit registers keep only bits 12 to 2
  a_limit_read: assert property ( // [R16]
    (s.ptr == REG_HIGH || s.ptr == REG_LOW || s.ptr == REG_CRIT)
    |=> rdata[15:13] == 3'h0 && rdata[1:0] == 2'h0)
    else $error("limit read shows undefined bits");
  // locks are sticky until reset, so the hysteresis stays frozen
  a_lock_sticky: assert property ( // [R13]
    s.cfg.alarm_limit_lock |=> s.cfg.alarm_limit_lock)
    else $error("alarm lock cleared");

  c_crit_trip: cover property (sample_valid ##1 s.above_crit);
  c_int_clear: cover property (s.alert_q && s.cfg.alert_mode_int ##1 clear_req ##1 !s.alert_q);
  c_shutdown: cover property ($rose(s.cfg.shutdown_request) ##[1:20] $fell(s.cfg.shutdown_request));
  c_low_window: cover property ($rose(s.below_low));
  c_high_clear: cover property ($fell(s.above_high));

endmodule : thermal_capability_config_compare

// ### testbench/thermal_sample_engine.sv
`timescale 1ns/1ps
// stand-in for the sampling engine plus the pulled-up alert wire
module thermal_sample_engine (
  // clock
  input wire logic clk,
  // command from the bench
  input wire logic go,
  input wire logic [12:0] temp_cmd,
  // sample port toward the block
  output logic sample_valid = 1'b0,
  output logic [12:0] sample_temp = 13'h0aa,
  // open-drain alert pin
  input wire logic alert_out,
  input wire logic alert_oe,
  output wire logic alert_wire
);
  // one-cycle strobe; between samples the value toggles so stale data is never reused
  always_ff @(posedge clk) begin
    sample_valid <= go;
    sample_temp <= go ? temp_cmd : ~sample_temp;
  end
  // pull-up holds the wire high while nobody drives it
  assign alert_wire = alert_oe ? alert_out : 1'b1;
endmodule : thermal_sample_engine

// ### testbench/thermal_capability_config_compare_tb.sv
`timescale 1ns/1ps
module thermal_capability_config_compare_tb;
  import thermal_pkg::*;
  typedef struct {logic [15:0] exp; logic [15:0] mask; logic pin; string name;} note_s;
  logic clk;
  logic rst = 1'b1;
  reg_req_s req = '0;
  logic [15:0] rdata;
  logic sample_valid;
  logic [12:0] sample_temp;
  logic shutdown_active;
  logic [1:0] temp_resolution_field;
  logic alert_out;
  logic alert_oe;
  logic alert_wire;
  logic go = 1'b0;
  logic [12:0] temp_cmd = 13'h000;
  logic rd_go = 1'b0;
  logic [1:0] rd_d = 2'b00;
  int error_cnt = 0;
  int checked = 0;
  int t;
  int m;
  note_s note_q[$];
  note_s cur;

  thermal_capability_config_compare u_thermal_capability_config_compare (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .sample_valid(sample_valid),
    .sample_temp(sample_temp), .shutdown_active(shutdown_active),
    .temp_resolution_field(temp_resolution_field), .alert_out(alert_out), .alert_oe(alert_oe));
  thermal_sample_engine u_thermal_sample_engine (
    .clk(clk), .go(go), .temp_cmd(temp_cmd), .sample_valid(sample_valid),
    .sample_temp(sample_temp), .alert_out(alert_out), .alert_oe(alert_oe),
    .alert_wire(alert_wire));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // write pointer and data word in one cycle
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    @(posedge clk);
    req <= '{ptr_we: 1'b1, ptr: ptr, we: 1'b1, wdata: data};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // load pointer and note the word and pin level expected two edges later
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp, input logic [15:0] mask,
                    input logic pin, input string name);
    note_q.push_back('{exp, mask, pin, name});
    @(posedge clk);
    req <= '{ptr_we: 1'b1, ptr: ptr, we: 1'b0, wdata: 16'h0000};
    rd_go <= 1'b1;
    @(posedge clk);
    req <= '0;
    rd_go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd

  // hand one measurement to the engine stand-in and let the flags settle
  task automatic smp(input int v);
    @(posedge clk);
    go <= 1'b1;
    temp_cmd <= 13'(v);
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : smp

  // take the oldest note once its read word has settled
  always @(posedge clk) begin
    rd_d <= {rd_d[0], rd_go};
    if (rd_d[1] && note_q.size() > 0) begin
      cur = note_q.pop_front();
      check(cur.name, rdata & cur.mask, cur.exp);
      check("alert pin", {15'h0000, alert_wire}, {15'h0000, cur.pin});
    end
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    void'($urandom(85));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values; bit 5 may read either way
    rd(REG_CAP, CAP_RESET, 16'hffdf, 1'b1, "capability");
    rd(REG_CFG, CFG_RESET, 16'hffff, 1'b1, "config");
    wr(REG_CAP, 16'($urandom()) | 16'hff00);
    rd(REG_CAP, CAP_RESET, 16'hffdf, 1'b1, "capability after write");
    wr(REG_CFG, 16'hf800);
    rd(REG_CFG, 16'h0000, 16'hffff, 1'b1, "config reserved");
    // every resolution with a random positive reading, limits out of the way
    wr(REG_HIGH, 16'h07d0);
    wr(REG_CRIT, 16'h07d0);
    for (int r = 0; r < 4; r++) begin
      t = 16 + int'($urandom_range(1584));
      wr(REG_RES, 16'(r * 8 + 7));
      rd(REG_CAP, (CAP_RESET & 16'hffe7) | 16'(r * 8), 16'hffdf, 1'b1, "cap res");
      check("resolution out", {14'h0000, temp_resolution_field}, 16'(r));
      smp(t);
      rd(REG_TEMP, 16'(t) & (16'h1fff << (3 - r)), 16'hffff, 1'b1, "temp word");
    end
    // comparator mode, each hysteresis setting against a 50 degree high limit;
    // only bits 12:2 compare, so the first reading above it is 804
    wr(REG_HIGH, 16'h0320);
    for (int h = 0; h < 4; h++) begin
      m = (h == 0) ? 0 : 24 << (h - 1);
      wr(REG_CFG, 16'(h * 512 + 8));
      smp(804);
      rd(REG_TEMP, 16'h4324, 16'hffff, 1'b0, "above high");
      wr(REG_CFG, 16'(h * 512 + 8));
      rd(REG_CFG, 16'(h * 512 + 24), 16'hffff, 1'b0, "status kept");
      smp(804 - m);
      rd(REG_TEMP, 16'h4000 | 16'(804 - m), 16'hffff, 1'b0, "above margin");
      smp(803 - m);
      rd(REG_TEMP, 16'(803 - m), 16'hffff, 1'b1, "at margin");
    end
    // negative lower limit with a 1.5 degree margin
    wr(REG_CFG, 16'h0208);
    wr(REG_LOW, 16'h1ff0);
    smp(-40);
    rd(REG_TEMP, 16'(-40) & 16'h1fff, 16'hffff, 1'b1, "low minus margin");
    smp(-44);
    rd(REG_TEMP, 16'h2000 | (16'(-44) & 16'h1fff), 16'hffff, 1'b0, "below");
    smp(-17);
    rd(REG_TEMP, 16'h2000 | (16'(-17) & 16'h1fff), 16'hffff, 1'b0, "under low");
    smp(-16);
    rd(REG_TEMP, 16'(-16) & 16'h1fff, 16'hffff, 1'b1, "at low");
    // interrupt mode: clear releases a window alert but not a critical one
    wr(REG_CFG, 16'h0209);
    smp(804);
    rd(REG_CFG, 16'h0219, 16'hffff, 1'b0, "interrupt raised");
    wr(REG_CFG, 16'h0229);
    rd(REG_CFG, 16'h0209, 16'hffff, 1'b1, "interrupt cleared");
    wr(REG_CRIT, 16'h0500);
    smp(1297);
    rd(REG_TEMP, 16'hc511, 16'hffff, 1'b0, "critical");
    wr(REG_CFG, 16'h0229);
    rd(REG_CFG, 16'h0219, 16'hffff, 1'b0, "critical held");
    // shutdown freezes the alert and ignores samples
    wr(REG_CFG, 16'h0309);
    smp(0);
    check("shutdown out", {15'h0000, shutdown_active}, 16'h0001);
    rd(REG_TEMP, 16'hc511, 16'hffff, 1'b0, "shutdown frozen");
    // a lock bit freezes the hysteresis field
    wr(REG_CFG, 16'h0289);
    wr(REG_CFG, 16'h0689);
    rd(REG_CFG, 16'h0289, 16'hffef, 1'b0, "hyst locked");
    finish_test();
  end
endmodule : thermal_capability_config_compare_tb
